// file: core/run_enable_input_logic.sv
// Purpose: Run, reverse and enable processing of the drive command path
// Assumes: pclk 200 MHz; terminal pins asynchronous to pclk
// Notes:   Registers over APB; one wait state on every access

`timescale 1ns/10ps

module run_enable_input_logic
    import run_enable_pkg::*;
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [DATA_W-1:0]    pwdata,
    output logic      [DATA_W-1:0]    prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Terminal pins
    input  wire logic [7:0]           main_input_line,
    input  wire logic [3:0]           multipurpose_line,
    input  wire logic [3:0]           further_input_line,
    input  wire logic [7:0]           expansion_input_line,
    input  wire logic                 hard_enable_a,
    input  wire logic                 hard_enable_b,
    // Serial or fieldbus copy of the enable line
    input  wire logic                 link_enable_line,
    // Drive commands
    output logic                      drive_enable,
    output logic                      output_voltage_zero,
    output logic                      run_forward,
    output logic                      run_reverse
);

    localparam int RAW_W = NUM_LINES + 2;

    // Byte addresses from word indices
    localparam logic [ADDR_W-1:0] A_SOFT_EN = {IDX_SOFT_EN[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_REV_B   = {IDX_REV_B[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_CTRL    = {IDX_CTRL[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_REV_A   = {IDX_REV_A[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_DISABLE = {IDX_DISABLE[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_START   = {IDX_START[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_MASK    = {IDX_DELAY_MASK[13:0], 2'b00};
    localparam logic [ADDR_W-1:0] A_STATUS  = {IDX_STATUS[13:0], 2'b00};

    logic [SEL_W-1:0]     soft_sel;
    logic [SEL_W-1:0]     rev_b_sel;
    logic [SEL_W-1:0]     rev_a_sel;
    logic [SEL_W-1:0]     dis_sel;
    logic [SEL_W-1:0]     start_sel;
    logic [2:0]           ctrl;
    logic [NUM_LINES-1:0] delay_mask;
    logic [RAW_W-1:0]     raw;
    logic [RAW_W-1:0]     sync1;
    logic [RAW_W-1:0]     sync2;
    logic [RAW_W-1:0]     sync3;
    logic [RAW_W-1:0]     clean;
    logic [NUM_LINES-1:0] delayed;
    logic                 exp_fitted;
    logic                 board_b;
    logic                 link_sel;
    logic                 soft_act;
    logic                 soft_used;
    logic                 rev_a_act;
    logic                 rev_b_act;
    logic                 dis_act;
    logic                 dis_used;
    logic                 start_act;
    logic                 rev_eff;
    logic                 access;
    logic                 addr_ok;
    logic [DATA_W-1:0]    next_rdata;
    logic                 next_drive_enable;
    logic                 next_run_forward;
    logic                 next_run_reverse;

    assign exp_fitted = ctrl[CTRL_EXP_BIT];
    assign board_b    = ctrl[CTRL_BOARD_BIT];
    assign link_sel   = ctrl[CTRL_LINK_BIT];
    assign raw        = {hard_enable_b, hard_enable_a, expansion_input_line,
                         further_input_line, multipurpose_line, main_input_line};

    // Three-stage synchroniser; only stage two feeds stage three
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clean <= '0;
        end else begin
            for (int i = 0; i < RAW_W; i++) begin
                if (sync2[i] == sync3[i]) begin
                    clean[i] <= sync3[i];
                end
            end
        end
    end

    // Per-terminal delay timers; masked lines follow after DELAY_CYC
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_delay
            logic [7:0] cnt;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt        <= 8'h00;
                    delayed[g] <= 1'b0;
                end else if (!delay_mask[g] || clean[g] == delayed[g]) begin
                    cnt        <= 8'h00;
                    delayed[g] <= clean[g];
                end else if (cnt == 8'(DELAY_CYC - 1)) begin
                    cnt        <= 8'h00;
                    delayed[g] <= clean[g];
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    endgenerate

    // Soft enable taps the undelayed line; all others the delayed one
    input_line_select u_soft (
        .sel        (soft_sel),
        .exp_fitted (exp_fitted),
        .lines      (clean[NUM_LINES-1:0]),
        .active     (soft_act),
        .used       (soft_used)
    );
    input_line_select u_rev_a (
        .sel        (rev_a_sel),
        .exp_fitted (exp_fitted),
        .lines      (delayed),
        .active     (rev_a_act),
        .used       ()
    );
    input_line_select u_rev_b (
        .sel        (rev_b_sel),
        .exp_fitted (exp_fitted),
        .lines      (delayed),
        .active     (rev_b_act),
        .used       ()
    );
    input_line_select u_dis (
        .sel        (dis_sel),
        .exp_fitted (exp_fitted),
        .lines      (delayed),
        .active     (dis_act),
        .used       (dis_used)
    );
    input_line_select u_start (
        .sel        (start_sel),
        .exp_fitted (exp_fitted),
        .lines      (delayed),
        .active     (start_act),
        .used       ()
    );

    // Enable chain and run commands
    always_comb begin
        rev_eff = board_b ? rev_b_act : rev_a_act;
        next_drive_enable = clean[NUM_LINES] && clean[NUM_LINES+1]
                            && delayed[1]
                            && (!soft_used || soft_act)
                            && (!link_sel || link_enable_line)
                            && !dis_act;
        // Both together is a stop; nothing runs while disabled
        next_run_forward = next_drive_enable && start_act && !rev_eff;
        next_run_reverse = next_drive_enable && rev_eff && !start_act;
    end

    // Drive command outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_enable        <= 1'b0;
            output_voltage_zero <= 1'b1;
            run_forward         <= 1'b0;
            run_reverse         <= 1'b0;
        end else begin
            drive_enable        <= next_drive_enable;
            output_voltage_zero <= !next_drive_enable;
            run_forward         <= next_run_forward;
            run_reverse         <= next_run_reverse;
        end
    end

    // APB decode; access phase only, answer one cycle later
    assign access = psel && penable && !pready;
    always_comb begin
        addr_ok    = 1'b1;
        next_rdata = '0;
        if (paddr == A_SOFT_EN) begin
            next_rdata = {16'h0000, soft_sel};
        end else if (paddr == A_REV_B) begin
            next_rdata = {16'h0000, rev_b_sel};
        end else if (paddr == A_CTRL) begin
            next_rdata = {29'h0, ctrl};
        end else if (paddr == A_REV_A) begin
            next_rdata = {16'h0000, rev_a_sel};
        end else if (paddr == A_DISABLE) begin
            next_rdata = {16'h0000, dis_sel};
        end else if (paddr == A_START) begin
            next_rdata = {16'h0000, start_sel};
        end else if (paddr == A_MASK) begin
            next_rdata = {8'h00, delay_mask};
        end else if (paddr == A_STATUS) begin
            next_rdata[STAT_ENABLE_BIT] = drive_enable;
            next_rdata[STAT_FWD_BIT]    = run_forward;
            next_rdata[STAT_REV_BIT]    = run_reverse;
            next_rdata[STAT_SOFT_BIT]   = soft_used;
            next_rdata[STAT_DIS_BIT]    = dis_act;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Bus answer; status is read only, so writes to it are errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access;
            pslverr <= access && (!addr_ok || (pwrite && paddr == A_STATUS));
            if (access && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // Register writes land at the edge that completes the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_sel   <= SEL_RESET;
            rev_b_sel  <= SEL_RESET;
            rev_a_sel  <= SEL_RESET;
            dis_sel    <= SEL_RESET;
            start_sel  <= SEL_RESET;
            ctrl       <= CTRL_RESET;
            delay_mask <= MASK_RESET;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == A_SOFT_EN) begin
                soft_sel <= pwdata[SEL_W-1:0];
            end else if (paddr == A_REV_B) begin
                rev_b_sel <= pwdata[SEL_W-1:0];
            end else if (paddr == A_CTRL) begin
                ctrl <= pwdata[2:0];
            end else if (paddr == A_REV_A) begin
                rev_a_sel <= pwdata[SEL_W-1:0];
            end else if (paddr == A_DISABLE) begin
                dis_sel <= pwdata[SEL_W-1:0];
            end else if (paddr == A_START) begin
                start_sel <= pwdata[SEL_W-1:0];
            end else if (paddr == A_MASK) begin
                delay_mask <= pwdata[NUM_LINES-1:0];
            end
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sel_decode: assert property ((soft_sel != 16'h0000 && soft_sel <= 16'h0010)
        |-> soft_used && soft_act == clean[5'(soft_sel[4:0] - 5'h01)])
        else $error("selector in range not decoded");
    a_sel_invalid: assert property ((soft_sel > 16'h0018 || (soft_sel > 16'h0010 && !exp_fitted))
        |-> !soft_used && !soft_act)
        else $error("invalid selector code not inactive");
    a_rev_b_source: assert property (board_b && rev_b_act && !start_act && next_drive_enable
        |=> run_reverse)
        else $error("reverse B ignored on board B");
    a_soft_series: assert property (soft_used && !soft_act |=> !drive_enable)
        else $error("enabled without soft enable");
    a_second_main: assert property (!delayed[1] |=> !drive_enable)
        else $error("enabled without second main input");
    a_soft_nodelay: assert property (soft_used && $changed(clean[NUM_LINES-1:0])
        |-> soft_act == clean[5'(soft_sel[4:0] - 5'h01)])
        else $error("soft enable was delayed");
    a_link_gate: assert property (link_sel && !link_enable_line |=> !drive_enable)
        else $error("enabled without link enable");
    a_disable_force: assert property (dis_act |=> !drive_enable && output_voltage_zero)
        else $error("disable did not force off");
    a_start_rev_stop: assert property (start_act && rev_eff
        |=> !run_forward && !run_reverse)
        else $error("start with reverse did not stop");

    c_enable_rise: cover property ($rose(drive_enable));
    c_run_rev: cover property (run_reverse && board_b);
    c_disable: cover property (dis_used && dis_act ##1 output_voltage_zero);

endmodule // run_enable_input_logic

// file: core/run_enable_pkg.sv
// Purpose: Shared constants for the run and enable input logic
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register indices are word indices; byte address is four times

package run_enable_pkg;

    // Bus widths
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 32;
    localparam int SEL_W     = 16;
    localparam int NUM_LINES = 24;

    // Register word indices
    localparam logic [ADDR_W-1:0] IDX_SOFT_EN    = 16'h0480;
    localparam logic [ADDR_W-1:0] IDX_REV_B      = 16'h0513;
    localparam logic [ADDR_W-1:0] IDX_CTRL       = 16'h0600;
    localparam logic [ADDR_W-1:0] IDX_REV_A      = 16'h0601;
    localparam logic [ADDR_W-1:0] IDX_DISABLE    = 16'h0602;
    localparam logic [ADDR_W-1:0] IDX_START      = 16'h0603;
    localparam logic [ADDR_W-1:0] IDX_DELAY_MASK = 16'h0604;
    localparam logic [ADDR_W-1:0] IDX_STATUS     = 16'h0605;

    // Reset values
    localparam logic [SEL_W-1:0]     SEL_RESET  = 16'h0000;
    localparam logic [2:0]           CTRL_RESET = 3'h0;
    localparam logic [NUM_LINES-1:0] MASK_RESET = 24'h000000;

    // Control field positions
    localparam int CTRL_EXP_BIT   = 0;
    localparam int CTRL_BOARD_BIT = 1;
    localparam int CTRL_LINK_BIT  = 2;

    // Status field positions
    localparam int STAT_ENABLE_BIT = 0;
    localparam int STAT_FWD_BIT    = 1;
    localparam int STAT_REV_BIT    = 2;
    localparam int STAT_SOFT_BIT   = 3;
    localparam int STAT_DIS_BIT    = 4;

    // Selector code ranges
    localparam logic [SEL_W-1:0] SEL_INACTIVE     = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_FURTHER_LAST = 16'h0010;
    localparam logic [SEL_W-1:0] SEL_EXP_LAST     = 16'h0018;

    // Input delay timer
    localparam int CLK_PERIOD_NS  = 5;
    localparam int INPUT_DELAY_NS = 1000;
    localparam int DELAY_CYC      = (INPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: core/input_line_select.sv
// Purpose: Pick one input line for a function from its selector code
// Assumes: Lines ordered main 1-8, multipurpose, further, expansion
// Notes:   Purely combinational; one instance per function

`timescale 1ns/10ps

module input_line_select
    import run_enable_pkg::*;
(
    // Configuration
    input  wire logic [SEL_W-1:0]     sel,
    input  wire logic                 exp_fitted,
    // Candidate lines
    input  wire logic [NUM_LINES-1:0] lines,
    // Result
    output logic                      active,
    output logic                      used
);

    // Expansion codes count only with the board fitted
    function automatic logic code_valid(input logic [SEL_W-1:0] code, input logic exp);
        if (code == SEL_INACTIVE) begin
            return 1'b0;
        end else if (code <= SEL_FURTHER_LAST) begin
            return 1'b1;
        end else if (code <= SEL_EXP_LAST) begin
            return exp;
        end else begin
            return 1'b0;
        end
    endfunction

    // Out of range codes fall back to inactive
    always_comb begin
        used   = code_valid(sel, exp_fitted);
        active = used ? lines[5'(sel[4:0] - 5'h01)] : 1'b0;
    end

endmodule // input_line_select

// file: testbench/terminal_board_model.sv
// Purpose: Far side model: terminal board pins and link enable copy
// Assumes: Bench gives wanted levels; pins move one edge after them
// Notes:   Idle link copy toggles, so a stale level is never trusted

`timescale 1ns/10ps

module terminal_board_model (
    // Clock
    input  wire logic        pclk,
    // Wanted levels from the bench
    input  wire logic [23:0] want_lines,
    input  wire logic [1:0]  want_hard,
    input  wire logic        link_sel,
    input  wire logic        link_ok,
    // Pins towards the drive
    output logic      [7:0]  main_input_line,
    output logic      [3:0]  multipurpose_line,
    output logic      [3:0]  further_input_line,
    output logic      [7:0]  expansion_input_line,
    output logic             hard_enable_a,
    output logic             hard_enable_b,
    output logic             link_enable_line
);
    // Quiet board at power up
    initial begin
        {expansion_input_line, further_input_line, multipurpose_line} = '0;
        {main_input_line, hard_enable_a, hard_enable_b, link_enable_line} = '0;
    end
    // Pins follow the wanted levels like contacts
    always @(posedge pclk) begin
        {expansion_input_line, further_input_line} <= want_lines[23:12];
        {multipurpose_line, main_input_line} <= want_lines[11:0];
        {hard_enable_b, hard_enable_a} <= want_hard;
    end
    // Selected link source raises its copy only when told to
    always @(posedge pclk) begin
        if (link_sel) begin
            link_enable_line <= link_ok;
        end else begin
            link_enable_line <= ~link_enable_line;
        end
    end
endmodule // terminal_board_model

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the run and enable input logic
// Assumes: One wait state APB slave; pins settle within 14 cycles
// Notes:   Expected outputs come from a small integer model

`timescale 1ns/10ps

module testbench;
    import run_enable_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready, pslverr;
    logic [7:0]        main_input_line, expansion_input_line;
    logic [3:0]        multipurpose_line, further_input_line;
    logic              hard_enable_a, hard_enable_b, link_enable_line;
    logic              drive_enable, output_voltage_zero, run_forward, run_reverse;
    logic [23:0]       want_lines = '0;
    logic [1:0]        want_hard = '0;
    logic              link_sel = 1'b0;
    logic              link_ok = 1'b0;
    logic [31:0]       d;
    logic              e;
    int                errors = 0;
    int                total_checks = 0;
    integer            seed = 32'hD36BFD20;
    int                sel[5];
    int                ctrl, mask;
    logic [ADDR_W-1:0] idx_tab[5] = '{IDX_SOFT_EN, IDX_REV_B, IDX_REV_A, IDX_DISABLE, IDX_START};

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    run_enable_input_logic u_run_enable_input_logic (.*);
    terminal_board_model u_terminal_board_model (.*);

    task automatic fail(input string what);
        errors++;
        $display("ERROR %0t: %s", $time, what);
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) fail(what);
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb_xfer(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
        int n;
        paddr <= {idx[13:0], 2'b00};
        pwrite <= wr;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("no pready");
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Selector decode: -1 inactive, else the picked line level
    function automatic int pick(int s);
        if (s < 1 || s > 24 || (s > 16 && !ctrl[0])) return -1;
        return int'(want_lines[s-1]);
    endfunction
    // Status image {disable, soft valid, reverse, forward, enable}
    function automatic logic [4:0] model();
        int sf, ds, rv, st, en;
        sf = pick(sel[0]);
        ds = pick(sel[3]);
        rv = pick(ctrl[1] ? sel[1] : sel[2]) == 1;
        st = pick(sel[4]) == 1;
        en = want_hard[0] & want_hard[1] & want_lines[1] & (sf != 0) & (ds != 1)
             & (!ctrl[2] | link_ok);
        return {ds == 1, sf != -1, en && rv && !st, en && st && !rv, en != 0};
    endfunction
    task automatic check_outputs();
        logic [4:0] m;
        m = model();
        check_val({drive_enable, output_voltage_zero, run_forward, run_reverse},
                  {m[0], !m[0], m[1], m[2]}, "drive outputs");
    endtask
    task automatic apply_cfg();
        for (int i = 0; i < 5; i++) apb_xfer(idx_tab[i], 1'b1, sel[i]);
        apb_xfer(IDX_CTRL, 1'b1, ctrl);
        apb_xfer(IDX_DELAY_MASK, 1'b1, mask);
        link_sel <= ctrl[2];
    endtask
    task automatic settle_check(input int n);
        repeat (n) @(posedge pclk);
        check_outputs();
    endtask

    // Watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        fail("watchdog expired");
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        sel = '{0, 0, 0, 0, 0};
        ctrl = 0;
        mask = 0;
        settle_check(2);
        for (int i = 0; i < 5; i++) begin
            apb_xfer(idx_tab[i], 1'b0, 0);
            check_val(d, 0, "selector reset value");
        end
        apb_xfer(IDX_SOFT_EN, 1'b1, 32'hFFFF0013);
        apb_xfer(IDX_SOFT_EN, 1'b0, 0);
        check_val(d, 32'h00000013, "selector readback");
        apb_xfer(16'h0700, 1'b0, 0);
        check_val({e, d[30:0]}, 32'h80000000, "unmapped read");
        apb_xfer(IDX_STATUS, 1'b1, 32'h1F);
        check_val(e, 1, "status write");
        $display("register test done");
        // Soft selector codes 0 to 26, with and without expansion board
        want_hard <= 2'b11;
        for (int c = 0; c < 27; c++) begin
            for (int x = 0; x < 2; x++) begin
                sel[0] = c;
                ctrl = x;
                want_lines <= (c > 0) ? ~(24'h1 << (c - 1)) : 24'hFFFFFF;
                apply_cfg();
                settle_check(14);
            end
        end
        $display("selector decode test done");
        sel = '{0, 4, 3, 0, 5};
        for (int k = 0; k < 8; k++) begin
            ctrl = k[0] << 1;
            want_lines <= 24'h2 | (k[1] ? 24'h10 : 24'h0) | (k[2] ? 24'h8 : 24'h4);
            apply_cfg();
            settle_check(14);
        end
        $display("reverse board test done");
        sel = '{0, 0, 0, 7, 0};
        for (int k = 0; k < 4; k++) begin
            ctrl = 4;
            link_ok <= k[0];
            want_lines <= k[1] ? 24'h42 : 24'h2;
            apply_cfg();
            settle_check(14);
        end
        $display("link and disable test done");
        // Delay on every line: soft enable still immediate, main input 2 late
        sel = '{6, 0, 0, 0, 0};
        ctrl = 0;
        mask = 24'hFFFFFF;
        want_lines <= 24'h22;
        apply_cfg();
        settle_check(230);
        want_lines <= 24'h02;
        settle_check(14);
        want_lines <= 24'h22;
        settle_check(14);
        want_lines <= 24'h20;
        repeat (14) @(posedge pclk);
        check_val(drive_enable, 1, "main input 2 not delayed");
        settle_check(220);
        mask = 0;
        apply_cfg();
        $display("delay test done");
        for (int i = 0; i < 40; i++) begin
            for (int k = 0; k < 5; k++) sel[k] = $random(seed) & 31;
            ctrl = $random(seed) & 7;
            d = $random(seed);
            want_hard <= d[0] ? 2'b11 : d[2:1];
            want_lines <= 24'($random(seed)) | (d[3] ? 24'h2 : 24'h0);
            link_ok <= d[4];
            apply_cfg();
            settle_check(14);
            apb_xfer(IDX_STATUS, 1'b0, 0);
            check_val(d, {27'h0, model()}, "status image");
        end
        $display("random test done");
        wrap_up();
    end
endmodule // testbench
